// *** core/scl_map.svh ***
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SCL_A_DR0      8'h00
`define SCL_A_DR1      8'h04
`define SCL_A_DR2      8'h08
`define SCL_A_DR3      8'h0c
`define SCL_A_PS0      8'h10
`define SCL_A_PS1      8'h14
`define SCL_A_CTRL     8'h18
`define SCL_A_STAT     8'h1c
// ****************************************************************
// Mode page constants and sense codes
// ****************************************************************
`define SCL_DR_CODE    6'h02
`define SCL_DR_LEN     8'h0e
`define SCL_PS_CODE    6'h19
`define SCL_PS_LEN     8'h06
`define SCL_PS_PROTO   4'h6
`define SCL_SK_ILLREQ  4'h5
`define SCL_ASC_FIELD  8'h26
`define SCL_CTRL_COMMIT 0
`define SCL_NXL_RST    16'h07d0
`define SCL_BLK_SHIFT  9
// ****************************************************************
// Timing
// ****************************************************************
`define SCL_CLK_NS     25
`define SCL_MS_NS      1000000
`define SCL_MS_CYC     (`SCL_MS_NS / `SCL_CLK_NS)
`define SCL_TICK100_MS 7'h64
`endif

// *** core/scl_pkg.sv ***
package scl_pkg;
  // Active connection limits, all in their page units
  typedef struct packed {
    logic [15:0] inact;
    logic [15:0] conn;
    logic [15:0] burst;
    logic [15:0] first;
    logic [15:0] nxloss;
  } scl_lim_t;

  // Outcome of the last page commit
  typedef struct packed {
    logic [7:0] asc;
    logic [3:0] skey;
    logic       chk;
    logic       ok;
  } scl_stat_t;

  // Close sequencing for the connection
  typedef enum logic [1:0] {SCL_IDLE, SCL_OPEN, SCL_WAITF, SCL_DONE} scl_conn_t;
endpackage

// *** core/scl_core.sv ***
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_core #(
  parameter int P_MS_CYC = `SCL_MS_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_conn_open,
  input  wire logic        i_conn_closed,
  input  wire logic        i_frame_tx,
  input  wire logic        i_frame_busy,
  input  wire logic        i_rd_frame,
  input  wire logic [15:0] i_rd_nexus,
  input  wire logic [15:0] i_rd_bytes,
  input  wire logic        i_rd_single,
  input  wire logic        i_wr_cmd,
  input  wire logic [31:0] i_wr_len,
  input  wire logic        i_xrdy_ack,
  input  wire logic        i_rej_nodest,
  input  wire logic        i_open_ok,
  output logic             o_done_req,
  output logic             o_rd_hold,
  output logic             o_xrdy_valid,
  output logic [31:0]      o_xrdy_len,
  output logic             o_nexus_loss
);
  import scl_pkg::*;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [31:0]     dr_ff [4];
  logic [31:0]     ps_ff [2];
  scl_lim_t        lim_ff;
  scl_stat_t       stat_ff;
  logic            pready_ff;
  logic            pslverr_ff;
  logic [31:0]     prdata_ff;
  logic [31:0]     nxt_prdata;
  logic            acc;
  logic            wr_take;
  logic            mapped;
  logic            commit;

  // Answer one cycle into the access phase; write lands at the pready edge
  assign acc     = i_psel && i_penable && !pready_ff;
  assign wr_take = i_psel && i_penable && pready_ff && i_pwrite && mapped;
  assign mapped  = (i_paddr[1:0] == 2'b00) && (i_paddr <= `SCL_A_STAT);
  assign commit  = wr_take && (i_paddr == `SCL_A_CTRL) && i_pwdata[`SCL_CTRL_COMMIT];
  // Read mux, unmapped reads return zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (i_paddr)
      `SCL_A_DR0:  nxt_prdata = dr_ff[0];
      `SCL_A_DR1:  nxt_prdata = dr_ff[1];
      `SCL_A_DR2:  nxt_prdata = dr_ff[2];
      `SCL_A_DR3:  nxt_prdata = dr_ff[3];
      `SCL_A_PS0:  nxt_prdata = ps_ff[0];
      `SCL_A_PS1:  nxt_prdata = ps_ff[1];
      `SCL_A_STAT: nxt_prdata = {18'h0, stat_ff};
      default:     nxt_prdata = 32'h0000_0000;
    endcase
  end
  // Bus handshake flops
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc && !mapped;
      prdata_ff  <= acc ? nxt_prdata : 32'h0000_0000;
    end
  end

  // Page image words; a word write stores the whole 32 bits
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dr
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          dr_ff[g] <= 32'h0000_0000;
        end else if (wr_take && i_paddr == (`SCL_A_DR0 + 8'(g * 4))) begin
          dr_ff[g] <= i_pwdata;
        end
      end
    end
    for (g = 0; g < 2; g++) begin : g_ps
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          ps_ff[g] <= 32'h0000_0000;
        end else if (wr_take && i_paddr == (`SCL_A_PS0 + 8'(g * 4))) begin
          ps_ff[g] <= i_pwdata;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Page validation
  // ****************************************************************
  logic [7:0] dr_b [16];
  logic [7:0] ps_b [8];
  logic       dr_ok;
  logic       ps_ok;
  generate
    for (g = 0; g < 16; g++) begin : g_drb
      assign dr_b[g] = dr_ff[g / 4][8 * (g % 4) +: 8];
    end
    for (g = 0; g < 8; g++) begin : g_psb
      assign ps_b[g] = ps_ff[g / 4][8 * (g % 4) +: 8];
    end
  endgenerate

  // Byte 0 holds the saveable flag in bit 7, which is allowed either way
  assign dr_ok = (dr_b[0][5:0] == `SCL_DR_CODE) && (dr_b[1] == `SCL_DR_LEN)
              && !dr_b[0][6] && (dr_b[2] == 8'h00) && (dr_b[3] == 8'h00)
              && (dr_b[6] == 8'h00) && (dr_b[7] == 8'h00)
              && (dr_b[12] == 8'h00) && (dr_b[13] == 8'h00);
  assign ps_ok = (ps_b[0][5:0] == `SCL_PS_CODE) && (ps_b[1] == `SCL_PS_LEN)
              && !ps_b[0][6] && (ps_b[2] == {4'h0, `SCL_PS_PROTO})
              && (ps_b[3] == 8'h00) && (ps_b[6] == 8'h00)
              && (ps_b[7] == 8'h00);

  // Limits only change on a clean commit, so a bad page leaves the old ones
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      lim_ff  <= '{inact: 16'h0000, conn: 16'h0000, burst: 16'h0000,
                   first: 16'h0000, nxloss: `SCL_NXL_RST};
      stat_ff <= '0;
    end else if (commit) begin
      if (dr_ok && ps_ok) begin
        lim_ff  <= '{inact: {dr_b[4], dr_b[5]}, conn: {dr_b[8], dr_b[9]},
                     burst: {dr_b[10], dr_b[11]}, first: {dr_b[14], dr_b[15]},
                     nxloss: {ps_b[4], ps_b[5]}};
        stat_ff <= '{asc: 8'h00, skey: 4'h0, chk: 1'b0, ok: 1'b1};
      end else begin
        stat_ff <= '{asc: `SCL_ASC_FIELD, skey: `SCL_SK_ILLREQ,
                     chk: 1'b1, ok: 1'b0};
      end
    end
  end

  // ****************************************************************
  // Time base
  // ****************************************************************
  logic [31:0] ms_cnt_ff;
  logic [6:0]  t100_cnt_ff;
  logic        ms_tick_ff;
  logic        t100_tick_ff;
  logic        ms_wrap;
  logic        t100_wrap;

  assign ms_wrap   = (ms_cnt_ff == 32'(P_MS_CYC - 1));
  assign t100_wrap = ms_wrap && (t100_cnt_ff == (`SCL_TICK100_MS - 7'h01));

  // Restarted on open so each connection starts on a full period
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_conn_open) begin
      ms_cnt_ff    <= 32'h0000_0000;
      t100_cnt_ff  <= 7'h00;
      ms_tick_ff   <= 1'b0;
      t100_tick_ff <= 1'b0;
    end else begin
      ms_cnt_ff    <= ms_wrap ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
      t100_cnt_ff  <= ms_wrap ? (t100_wrap ? 7'h00 : t100_cnt_ff + 7'h01) : t100_cnt_ff;
      ms_tick_ff   <= ms_wrap;
      t100_tick_ff <= t100_wrap;
    end
  end

  // ****************************************************************
  // Inactivity and duration limits
  // ****************************************************************
  scl_conn_t   st_ff;
  scl_conn_t   nxt_st;
  logic [15:0] idle_ff;
  logic [15:0] dur_ff;
  logic        idle_over;
  logic        dur_over;
  logic        burst_close;

  assign idle_over = (lim_ff.inact != 16'h0000) && (idle_ff > lim_ff.inact);
  assign dur_over  = (lim_ff.conn != 16'h0000) && (dur_ff >= lim_ff.conn);

  // Counters saturate rather than wrap so a long gap cannot look short
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_conn_open) begin
      idle_ff <= 16'h0000;
      dur_ff  <= 16'h0000;
    end else begin
      if (i_frame_tx) begin
        idle_ff <= 16'h0000;
      end else if (t100_tick_ff && idle_ff != 16'hffff) begin
        idle_ff <= idle_ff + 16'h0001;
      end
      if (t100_tick_ff && dur_ff != 16'hffff) begin
        dur_ff <= dur_ff + 16'h0001;
      end
    end
  end

  // Close sequencing; DONE request holds until the link closes
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      SCL_IDLE:  if (i_conn_open) nxt_st = SCL_OPEN;
      SCL_OPEN: begin
        if (idle_over || burst_close) begin
          nxt_st = SCL_DONE;
        end else if (dur_over) begin
          nxt_st = i_frame_busy ? SCL_WAITF : SCL_DONE;
        end
      end
      SCL_WAITF: if (!i_frame_busy) nxt_st = SCL_DONE;
      SCL_DONE:  nxt_st = SCL_DONE;
    endcase
    if (i_conn_closed) begin
      nxt_st = SCL_IDLE;
    end
  end

  // State and DONE request flops
  logic done_ff;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff   <= SCL_IDLE;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      done_ff <= (nxt_st == SCL_DONE);
    end
  end

  // ****************************************************************
  // Read burst per nexus
  // ****************************************************************
  logic [15:0] nex_ff;
  logic [31:0] rd_cnt_ff;
  logic [31:0] nxt_rd_cnt;
  logic [31:0] cap_bytes;
  logic        rd_hold_ff;
  logic        cap_on;

  assign cap_on     = (lim_ff.burst != 16'h0000);
  assign cap_bytes  = {16'h0000, lim_ff.burst} << `SCL_BLK_SHIFT;
  assign nxt_rd_cnt = (i_rd_nexus == nex_ff) ? rd_cnt_ff + {16'h0000, i_rd_bytes}
                                             : {16'h0000, i_rd_bytes};
  assign burst_close = rd_hold_ff && i_rd_single;

  // A frame for another nexus restarts the tally for that nexus
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_conn_open) begin
      nex_ff     <= 16'h0000;
      rd_cnt_ff  <= 32'h0000_0000;
      rd_hold_ff <= 1'b0;
    end else if (i_rd_frame) begin
      nex_ff     <= i_rd_nexus;
      rd_cnt_ff  <= nxt_rd_cnt;
      rd_hold_ff <= cap_on && (nxt_rd_cnt >= cap_bytes);
    end
  end

  // ****************************************************************
  // Write transfer requests
  // ****************************************************************
  logic [31:0] rem_ff;
  logic [31:0] fb_bytes;
  logic [31:0] rem_new;
  logic [31:0] rem_cur;
  logic [31:0] xr_len;
  logic        xr_valid_ff;
  logic [31:0] xr_len_ff;

  assign fb_bytes = {16'h0000, lim_ff.first} << `SCL_BLK_SHIFT;
  assign rem_new  = (i_wr_len > fb_bytes) ? i_wr_len - fb_bytes : 32'h0000_0000;
  assign rem_cur  = (xr_valid_ff && i_xrdy_ack) ? rem_ff - xr_len_ff : rem_ff;
  assign xr_len   = (cap_on && rem_cur > cap_bytes) ? cap_bytes : rem_cur;

  // Next request is offered as soon as the previous one is taken
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rem_ff      <= 32'h0000_0000;
      xr_valid_ff <= 1'b0;
      xr_len_ff   <= 32'h0000_0000;
    end else if (i_wr_cmd && !xr_valid_ff) begin
      rem_ff      <= rem_new;
      xr_valid_ff <= (rem_new != 32'h0000_0000);
      xr_len_ff   <= (cap_on && rem_new > cap_bytes) ? cap_bytes : rem_new;
    end else if (xr_valid_ff && i_xrdy_ack) begin
      rem_ff      <= rem_cur;
      xr_valid_ff <= (rem_cur != 32'h0000_0000);
      xr_len_ff   <= xr_len;
    end
  end

  // ****************************************************************
  // Nexus loss window
  // ****************************************************************
  logic        arm_ff;
  logic [15:0] rty_ff;
  logic        loss_ff;
  logic        loss_hit;

  assign loss_hit = arm_ff && (lim_ff.nxloss != 16'h0000)
                 && (rty_ff >= lim_ff.nxloss);

  // Window starts at the first no-destination reject, ends on a successful open (i_open_ok)
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_open_ok) begin
      arm_ff  <= 1'b0;
      rty_ff  <= 16'h0000;
      loss_ff <= 1'b0;
    end else begin
      loss_ff <= loss_hit;
      if (loss_hit) begin
        arm_ff <= 1'b0;
        rty_ff <= 16'h0000;
      end else if (i_rej_nodest && !arm_ff) begin
        arm_ff <= 1'b1;
        rty_ff <= 16'h0000;
      end else if (arm_ff && ms_tick_ff && rty_ff != 16'hffff) begin
        rty_ff <= rty_ff + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_prdata     = prdata_ff;
  assign o_pready     = pready_ff;
  assign o_pslverr    = pslverr_ff;
  assign o_done_req   = done_ff;
  assign o_rd_hold    = rd_hold_ff;
  assign o_xrdy_valid = xr_valid_ff;
  assign o_xrdy_len   = xr_len_ff;
  assign o_nexus_loss = loss_ff;
endmodule

// *** bench/scl_asserts.sv ***
`timescale 1ns/1ps
// ****************
// Port checks
// ****************
module scl_asserts #(
  parameter int P_MS_CYC = 4
) (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [7:0]  i_paddr,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_conn_open,
  input wire logic        i_conn_closed,
  input wire logic        i_frame_busy,
  input wire logic        i_rd_single,
  input wire logic        i_xrdy_ack,
  input wire logic        i_open_ok,
  input wire logic        o_done_req,
  input wire logic        o_rd_hold,
  input wire logic        o_xrdy_valid,
  input wire logic [31:0] o_xrdy_len,
  input wire logic        o_nexus_loss
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Bus answers with exactly one wait state
  a_apb_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready missing after access");
  a_bad_addr: assert property (o_pready && (i_paddr[1:0] != 2'b00 || i_paddr > 8'h1c)
    |-> o_pslverr) else $error("bad address not refused");
  a_done_holds: assert property (o_done_req && !i_conn_closed |=> o_done_req)
    else $error("done dropped before close");
  a_done_close: assert property (i_conn_closed |=> !o_done_req)
    else $error("done kept after close");
  a_done_frame: assert property ($rose(o_done_req) |-> !$past(i_frame_busy))
    else $error("done raised during a frame");
  a_burst_close: assert property ($rose(o_rd_hold) && i_rd_single |=> o_done_req)
    else $error("single nexus burst did not close");
  a_hold_open: assert property (i_conn_open |=> !o_rd_hold)
    else $error("burst hold kept over open");
  a_xrdy_len: assert property (o_xrdy_valid |-> o_xrdy_len != 32'h0)
    else $error("empty transfer request");
  a_xrdy_steady: assert property (o_xrdy_valid && !i_xrdy_ack
    |=> o_xrdy_valid && $stable(o_xrdy_len)) else $error("request changed unacked");
  a_loss_pulse: assert property (o_nexus_loss |=> !o_nexus_loss)
    else $error("loss longer than a pulse");
  a_loss_ok: assert property (i_open_ok |-> ##2 !o_nexus_loss [*4])
    else $error("loss after successful open");
endmodule

// *** bench/scl_init_model.sv ***
`timescale 1ns/1ps
// ****************
// Initiator port across the link
// ****************
module scl_init_model (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_slow,
  input  wire logic        i_xrdy_valid,
  input  wire logic [31:0] i_xrdy_len,
  input  wire logic        i_done_req,
  output logic             o_xrdy_ack,
  output logic             o_conn_closed,
  output logic [31:0]      o_granted
);
  logic [3:0] wait_ff;
  logic [1:0] close_ff;
  // Data may only follow a grant, so sent bytes never exceed granted ones
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wait_ff    <= 4'h0;
      o_xrdy_ack <= 1'b0;
      o_granted  <= 32'h0;
    end else begin
      o_xrdy_ack <= 1'b0;
      wait_ff    <= 4'h0;
      if (i_xrdy_valid && !o_xrdy_ack) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff == (i_slow ? 4'h8 : 4'h1)) begin
          o_xrdy_ack <= 1'b1;
          o_granted  <= o_granted + i_xrdy_len;
        end
      end
    end
  end
  // Close a few cycles after a DONE request
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !i_done_req || o_conn_closed) begin
      close_ff      <= 2'h0;
      o_conn_closed <= 1'b0;
    end else begin
      close_ff      <= close_ff + 2'h1;
      o_conn_closed <= (close_ff == 2'h2);
    end
  end
endmodule

// *** bench/scl_core_bench.sv ***
`timescale 1ns/1ps
`include "scl_map.svh"
// ****************
// Limit logic bench
// ****************
module scl_core_bench;
  localparam int MS = 4;
  localparam logic [31:0] BM [8] = '{32'h0, 32'h10000, 32'h100, 32'h40,
                                      32'h40, 32'h10000, 32'h1, 32'h1};
  localparam int BI [8] = '{0, 0, 0, 0, 4, 4, 4, 3};
  localparam logic [15:0] WB [4] = '{16'h1, 16'h1, 16'h0, 16'h2};
  localparam logic [15:0] WF [4] = '{16'h1, 16'h1, 16'h0, 16'h0};
  localparam logic [31:0] WL [4] = '{32'h800, 32'h100, 32'h400, 32'h5dc};
  localparam logic [31:0] WG [4] = '{32'h600, 32'h0, 32'h400, 32'h5dc};
  localparam logic [31:0] WM [4] = '{32'h200, 32'h0, 32'h400, 32'h400};
  logic        clk, rstn, psel, pen, pwr, cop, ccl, ftx, fbusy, serr;
  logic        rdf, rds, wrc, xack, rej, ook, slow, pready, pslverr;
  logic        done, hold, xval, loss;
  logic [7:0]  paddr;
  logic [15:0] nex, rbytes;
  logic [31:0] pwdata, prdata, wlen, xlen, granted, rd, mx, g;
  int          err_count = 0;
  int          num_checks = 0;
  int          n;
  scl_core #(.P_MS_CYC(MS)) dut (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_conn_open(cop), .i_conn_closed(ccl), .i_frame_tx(ftx),
    .i_frame_busy(fbusy), .i_rd_frame(rdf), .i_rd_nexus(nex), .i_rd_bytes(rbytes),
    .i_rd_single(rds), .i_wr_cmd(wrc), .i_wr_len(wlen), .i_xrdy_ack(xack),
    .i_rej_nodest(rej), .i_open_ok(ook), .o_done_req(done), .o_rd_hold(hold),
    .o_xrdy_valid(xval), .o_xrdy_len(xlen), .o_nexus_loss(loss));
  scl_init_model u_init (
    .i_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_xrdy_valid(xval), .i_xrdy_len(xlen),
    .i_done_req(done), .o_xrdy_ack(xack), .o_conn_closed(ccl), .o_granted(granted));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  // Request is held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    serr = pslverr;
    if (k >= 16) err_count++;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // One idle edge after each pulse keeps drivers from colliding
  task automatic pulse(input int s);
    case (s)
      0: cop <= 1'b1;
      1: ftx <= 1'b1;
      2: rej <= 1'b1;
      3: ook <= 1'b1;
      4: wrc <= 1'b1;
      default: rdf <= 1'b1;
    endcase
    @(posedge clk);
    {cop, ftx, rej, ook, wrc, rdf} <= 6'h0;
    @(posedge clk);
  endtask
  task automatic wt(input int s, input int m);
    n = 0;
    while ((s == 0 ? done : s == 1 ? loss : xval) !== 1'b1 && n < m) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic rdfr(input logic [15:0] x, input logic [15:0] b);
    nex <= x;
    rbytes <= b;
    pulse(5);
  endtask
  // Both pages are written with the saveable flag set, which must be ignored
  task automatic pages(input logic [15:0] ia, cn, bu, fb, ls, input int bad);
    logic [31:0] w [6];
    w[0] = {16'h0, `SCL_DR_LEN, 2'b10, `SCL_DR_CODE};
    w[1] = {16'h0, ia[7:0], ia[15:8]};
    w[2] = {bu[7:0], bu[15:8], cn[7:0], cn[15:8]};
    w[3] = {fb[7:0], fb[15:8], 16'h0};
    w[4] = {12'h0, `SCL_PS_PROTO, `SCL_PS_LEN, 2'b10, `SCL_PS_CODE};
    w[5] = {16'h0, ls[7:0], ls[15:8]};
    w[BI[bad]] ^= BM[bad];
    for (int i = 0; i < 6; i++) apb(1'b1, 8'(4 * i), w[i]);
    apb(1'b0, `SCL_A_DR0, 32'h0);
    chk(rd, w[0]);
    apb(1'b1, `SCL_A_CTRL, 32'h1 << `SCL_CTRL_COMMIT);
    apb(1'b0, `SCL_A_STAT, 32'h0);
    chk(rd, (bad != 0) ? {18'h0, `SCL_ASC_FIELD, `SCL_SK_ILLREQ, 2'b10} : 32'h1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {psel, pen, pwr, cop, ftx, fbusy, rdf, rds, wrc, rej, ook, slow} = 12'h0;
    {paddr, nex, rbytes, pwdata, wlen} = 104'h0;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    pulse(2);
    wt(1, 9000);
    rng(7980, 8020);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(serr), 32'h1);
    pages(16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 0);
    for (int b = 1; b < 8; b++) pages(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, b);
    // Idle gap, first plain and then restarted by a frame
    pulse(0);
    wt(0, 2000);
    rng(780, 820);
    repeat (8) @(posedge clk);
    chk(32'(done), 32'h0);
    pulse(0);
    repeat (600) @(posedge clk);
    pulse(1);
    wt(0, 2000);
    rng(560, 640);
    repeat (8) @(posedge clk);
    pages(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 0);
    pulse(0);
    wt(0, 1500);
    chk(32'(done), 32'h0);
    // Duration cap, then the cap landing inside a frame
    pages(16'h0, 16'h2, 16'h0, 16'h0, 16'h0, 0);
    pulse(0);
    wt(0, 1500);
    rng(780, 820);
    repeat (8) @(posedge clk);
    pulse(0);
    repeat (700) @(posedge clk);
    fbusy <= 1'b1;
    repeat (300) @(posedge clk);
    chk(32'(done), 32'h0);
    fbusy <= 1'b0;
    wt(0, 20);
    rng(1, 4);
    repeat (8) @(posedge clk);
    // Read bursts per nexus
    pages(16'h0, 16'h0, 16'h1, 16'h0, 16'h0, 0);
    pulse(0);
    rdfr(16'h1, 16'h100);
    chk(32'(hold), 32'h0);
    rdfr(16'h1, 16'h100);
    chk(32'(hold), 32'h1);
    rdfr(16'h2, 16'h100);
    chk(32'(hold), 32'h0);
    rds <= 1'b1;
    rdfr(16'h2, 16'h100);
    wt(0, 10);
    rng(0, 3);
    rds <= 1'b0;
    repeat (8) @(posedge clk);
    pages(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 0);
    pulse(0);
    rds <= 1'b1;
    rdfr(16'h1, 16'hffff);
    rdfr(16'h1, 16'hffff);
    chk(32'(hold | done), 32'h0);
    rds <= 1'b0;
    // Write requests, the last one against a slow initiator
    for (int i = 0; i < 4; i++) begin
      slow <= (i == 3);
      pages(16'h0, 16'h0, WB[i], WF[i], 16'h0, 0);
      g = granted;
      mx = 32'h0;
      wlen <= WL[i];
      pulse(4);
      wt(2, 6);
      while (xval === 1'b1 && n < 300) begin
        if (xlen > mx) mx = xlen;
        @(posedge clk);
        n++;
      end
      chk(granted - g, WG[i]);
      chk(mx, WM[i]);
    end
    // Retry window, cut short by a good open, and disabled
    pages(16'h0, 16'h0, 16'h0, 16'h0, 16'h3, 0);
    pulse(2);
    wt(1, 100);
    rng(8, 18);
    pulse(2);
    repeat (4) @(posedge clk);
    pulse(3);
    wt(1, 40);
    chk(32'(n), 32'd40);
    pages(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 0);
    pulse(2);
    wt(1, 200);
    chk(32'(n), 32'd200);
    conclude();
  end
  // Whole run is near 14000 cycles; this bound leaves ample margin
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule
bind scl_core scl_asserts #(.P_MS_CYC(P_MS_CYC)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_conn_open(i_conn_open), .i_conn_closed(i_conn_closed), .i_frame_busy(i_frame_busy),
  .i_rd_single(i_rd_single), .i_xrdy_ack(i_xrdy_ack), .i_open_ok(i_open_ok),
  .o_done_req(o_done_req), .o_rd_hold(o_rd_hold), .o_xrdy_valid(o_xrdy_valid),
  .o_xrdy_len(o_xrdy_len), .o_nexus_loss(o_nexus_loss));
